// *** fault_protection_supervisor_tb_top.sv ***
`timescale 1ns/10ps
module fault_protection_supervisor_tb_top;
  import fps_pkg::*;
  logic ref_clk_i, rst_n_i;
  fps_apb_req_s req;
  fps_apb_rsp_s rsp;
  fps_sense_s cmd, sense;
  fps_loop_s loop;
  logic gate_en, ar, lm, bi, rs, bs;
  logic [SETPOINT_W-1:0] sp;
  logic [3:0] outs;
  logic [31:0] rdat;
  logic serr;
  logic [29:0] lv;
  int error_cnt, num_checks, n, i;
  logic [7:0] ofs [12];
  logic [31:0] rv [12];
  assign outs = {rs, bi, lm, ar};

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  fps_supervisor DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .apb_i(req), .apb_o(rsp),
    .sense_i(sense), .loop_i(loop), .gate_enable_o(gate_en), .auto_restart_o(ar),
    .latch_mode_o(lm), .brown_in_mode_o(bi), .restart_o(rs), .burst_start_o(bs),
    .current_setpoint_o(sp));
  fps_stage_model STAGE (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .gate_enable_i(gate_en),
    .cmd_i(cmd), .sense_o(sense));

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task ok(input logic c, input string m);
    num_checks++;
    if (c !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge ref_clk_i);
  endtask
  // one apb transfer; sampled right after the edge, before its updates land
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk_i);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (rsp.pready !== 1'b1 && k < 50);
    rdat = rsp.prdata;
    serr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    ok(rsp.pready === 1'b1, "no pready");
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    ok(rdat === e, m);
  endtask
  // sel: 0 sleep, 1 latch, 2 brown-in, 3 restart pulse
  task wait_on(input int s, input int lim, input string m);
    int k;
    k = 0;
    while (outs[s] !== 1'b1 && k < lim) begin
      @(posedge ref_clk_i);
      k++;
    end
    ok(outs[s] === 1'b1, m);
  endtask
  task cause(input int b);
    apb(1'b0, OFS_STATUS, 32'h0);
    ok(rdat[b] === 1'b1, "cause bit");
    wr(OFS_STATUS, 32'h3FF);
  endtask
  // short limits so each sleep lasts only steps * base clocks
  task setup;
    wr(OFS_SAMPLE, 32'h4);
    wr(OFS_SLEEP_STEPS, 32'h2);
    wr(OFS_SLEEP_BASE, 32'h5);
  endtask
  task do_reset;
    rst_n_i <= 1'b0;
    cyc(4);
    rst_n_i <= 1'b1;
    cyc(1);
    setup();
  endtask
  task restore(input logic [7:0] a, input logic [31:0] r);
    cmd.zero_cross <= 1'b1;
    loop <= '{fb_setpoint: 10'h100, startup_setpoint: 10'h3FF, first_pulse_on_limit: 16'h10};
    wait_on(3, 60, "restart");
    cmd.startup_done <= 1'b1;
    cyc(1);
    cmd.startup_done <= 1'b0;
    wr(a, r);
  endtask
  task st_case(input logic [7:0] a, input logic [31:0] v, input logic [31:0] r, input int b);
    wr(a, v);
    cmd.startup_request <= 1'b1;
    cyc(1);
    cmd.startup_request <= 1'b0;
    wait_on(0, 80, "start-up fault");
    cause(b);
    restore(a, r);
    $display("test start-up cause %0d done", b);
  endtask

  initial begin
    #300000;
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    test_done();
  end

  initial begin
    rst_n_i = 1'b0;
    req = '0;
    cmd = '0;
    cmd.brown_in_ok = 1'b1;
    cmd.zero_cross = 1'b1;
    loop = '{fb_setpoint: 10'h100, startup_setpoint: 10'h3FF, first_pulse_on_limit: 16'h10};
    error_cnt = 0;
    num_checks = 0;
    ofs = '{OFS_CTRL, OFS_SAMPLE, OFS_CHECK, OFS_START_TO, OFS_OC1_BLANK, OFS_OC2_BLANK,
      OFS_CEIL_BLANK, OFS_MAX_CYCLES, OFS_SLEEP_STEPS, OFS_SLEEP_BASE, OFS_STATUS, OFS_LEVELS};
    rv = '{32'(RST_CTRL), 32'(RST_SAMPLE), 32'(RST_CHECK), 32'(RST_START_TO),
      32'(RST_OC1_BLANK), 32'(RST_OC2_BLANK), 32'(RST_CEIL_BLANK), 32'(RST_MAX_CYCLES),
      32'(RST_SLEEP_STEPS), 32'(RST_SLEEP_BASE), 32'h0, 32'(RST_LEVELS)};
    cyc(4);
    rst_n_i <= 1'b1;
    cyc(1);
    for (i = 0; i < 12; i++) rd(ofs[i], rv[i], "reset value");
    rd(8'h30, 32'h0, "unmapped read");
    ok(serr === 1'b1, "unmapped pslverr");
    setup();
    rd(OFS_SLEEP_BASE, 32'h5, "readback");
    cyc(40);
    ok(ar === 1'b0 && gate_en === 1'b1, "fault outside demag");
    $display("test registers done");
    cmd.aux_under_cmp <= 1'b1;
    wait_on(0, 20, "uv restart");
    ok(gate_en === 1'b0, "gates still on");
    cmd.aux_under_cmp <= 1'b0;
    n = 0;
    while (ar === 1'b1 && n < 200) begin
      @(posedge ref_clk_i);
      n++;
    end
    // entry and exit are each seen one edge late, hence the window
    ok(n >= 9 && n <= 11, "sleep length");
    ok(rs === 1'b1, "restart pulse");
    cause(CAUSE_OUT_UV);
    $display("test undervoltage done");
    cmd.burst <= 1'b1;
    cmd.aux_under_cmp <= 1'b1;
    cyc(40);
    ok(ar === 1'b0, "burst uv not masked");
    wr(OFS_CTRL, 32'h1);
    wait_on(0, 20, "burst uv enabled");
    cmd.burst <= 1'b0;
    cmd.aux_under_cmp <= 1'b0;
    restore(OFS_CTRL, 32'h2);
    cmd.aux_over_cmp <= 1'b1;
    wait_on(0, 20, "ov restart");
    ok(lm === 1'b0, "ov latched");
    cmd.aux_over_cmp <= 1'b0;
    restore(OFS_CTRL, 32'h0);
    cmd.aux_over_cmp <= 1'b1;
    wait_on(1, 20, "ov latch");
    cmd.aux_over_cmp <= 1'b0;
    cyc(30);
    ok(lm === 1'b1 && gate_en === 1'b0 && rs === 1'b0, "latch left");
    do_reset();
    ok(lm === 1'b0 && gate_en === 1'b1, "latch kept over reset");
    $display("test overvoltage done");
    cmd.peak_cmp <= 1'b1;
    cyc(1);
    cmd.peak_cmp <= 1'b0;
    wait_on(1, 3, "peak latch");
    cause(CAUSE_PEAK);
    do_reset();
    $display("test peak done");
    cmd.wake <= 1'b1;
    cyc(1);
    ok(bs === 1'b1, "burst start");
    cmd.input_overvoltage_cmp <= 1'b1;
    cyc(1);
    ok(bs === 1'b0, "burst start with ov");
    cmd.wake <= 1'b0;
    wait_on(0, 8, "input ov");
    cmd.input_overvoltage_cmp <= 1'b0;
    cause(CAUSE_INPUT_OV);
    restore(OFS_CTRL, 32'h0);
    $display("test input overvoltage done");
    for (i = 0; i < 3; i++) begin
      loop.fb_setpoint <= 10'h008;
      lv = 30'h3FFFFFFF;
      lv[10*i +: 10] = 10'h010;
      wr(OFS_LEVELS, 32'(lv));
      wr(OFS_OC1_BLANK + 8'(4 * i), 32'h8);
      loop.fb_setpoint <= 10'h020;
      cyc(6);
      loop.fb_setpoint <= 10'h008;
      cyc(3);
      loop.fb_setpoint <= 10'h020;
      cyc(6);
      ok(ar === 1'b0, "timer not cleared");
      if (i == 2) ok(sp === 10'h010, "set-point clamp");
      wait_on(0, 12, "timer trip");
      loop.fb_setpoint <= 10'h008;
      cause(CAUSE_OC1 + i);
      wr(OFS_LEVELS, 32'(RST_LEVELS));
      restore(OFS_OC1_BLANK + 8'(4 * i), 32'h8);
      $display("test timer %0d done", i);
    end
    cmd.zero_cross <= 1'b0;
    st_case(OFS_MAX_CYCLES, 32'h2, 32'(RST_MAX_CYCLES), CAUSE_SHORT);
    loop.startup_setpoint <= 10'h000;
    st_case(OFS_START_TO, 32'hA, 32'(RST_START_TO), CAUSE_START_TO);
    loop.first_pulse_on_limit <= 16'h1;
    st_case(OFS_SAMPLE, 32'h4, 32'h4, CAUSE_SHUNT);
    test_done();
  end
endmodule

// *** fps_pkg.sv ***
package fps_pkg;
  localparam int SETPOINT_W = 10;
  localparam int TIMER_W = 24;
  localparam int CAUSE_W = 10;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SAMPLE = 8'h04;
  localparam logic [7:0] OFS_CHECK = 8'h08;
  localparam logic [7:0] OFS_START_TO = 8'h0C;
  localparam logic [7:0] OFS_OC1_BLANK = 8'h10;
  localparam logic [7:0] OFS_OC2_BLANK = 8'h14;
  localparam logic [7:0] OFS_CEIL_BLANK = 8'h18;
  localparam logic [7:0] OFS_MAX_CYCLES = 8'h1C;
  localparam logic [7:0] OFS_SLEEP_STEPS = 8'h20;
  localparam logic [7:0] OFS_SLEEP_BASE = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_LEVELS = 8'h2C;
  // field positions
  localparam int CTRL_BURST_UV_BIT = 0;
  localparam int CTRL_OVP_AR_BIT = 1;
  localparam int CTRL_PEAK_AR_BIT = 2;
  localparam int LEV1_LSB = 0;
  localparam int LEV2_LSB = 10;
  localparam int CEIL_LSB = 20;
  localparam int STAT_STATE_LSB = 16;
  localparam int CAUSE_INPUT_OV = 0;
  localparam int CAUSE_START_TO = 1;
  localparam int CAUSE_SHUNT = 2;
  localparam int CAUSE_OC1 = 3;
  localparam int CAUSE_OC2 = 4;
  localparam int CAUSE_CEIL = 5;
  localparam int CAUSE_PEAK = 6;
  localparam int CAUSE_OUT_UV = 7;
  localparam int CAUSE_OUT_OV = 8;
  localparam int CAUSE_SHORT = 9;
  // reset values
  localparam logic [2:0] RST_CTRL = 3'h0;
  localparam logic [15:0] RST_SAMPLE = 16'h0064;
  localparam logic [23:0] RST_CHECK = 24'h00C350;
  localparam logic [23:0] RST_START_TO = 24'h0F4240;
  localparam logic [23:0] RST_OC1_BLANK = 24'h030D40;
  localparam logic [23:0] RST_OC2_BLANK = 24'h0186A0;
  localparam logic [23:0] RST_CEIL_BLANK = 24'h00C350;
  localparam logic [7:0] RST_MAX_CYCLES = 8'h10;
  localparam logic [7:0] RST_SLEEP_STEPS = 8'h04;
  localparam logic [23:0] RST_SLEEP_BASE = 24'h0186A0;
  // ceiling 0x3FF, level two 0x2EE, level one 0x2BC packed into one word
  localparam logic [29:0] RST_LEVELS = 30'h3FFBBABC;

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_LATCH, ST_BROWNIN} fps_mode_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } fps_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fps_apb_rsp_s;

  typedef struct packed {
    logic input_overvoltage_cmp;
    logic brown_in_ok;
    logic peak_cmp;
    logic aux_under_cmp;
    logic aux_over_cmp;
    logic demag;
    logic ls_on;
    logic hs_on;
    logic hs_pulse_start;
    logic hb_cycle_end;
    logic zero_cross;
    logic burst;
    logic wake;
    logic startup_request;
    logic startup_done;
  } fps_sense_s;

  typedef struct packed {
    logic [SETPOINT_W-1:0] fb_setpoint;
    logic [SETPOINT_W-1:0] startup_setpoint;
    logic [15:0] first_pulse_on_limit;
  } fps_loop_s;

  typedef struct packed {
    fps_mode_e mode;
    logic [2:0] ctrl;
    logic [15:0] sample_period;
    logic [TIMER_W-1:0] check_limit;
    logic [TIMER_W-1:0] start_to_limit;
    logic [TIMER_W-1:0] oc1_blank;
    logic [TIMER_W-1:0] oc2_blank;
    logic [TIMER_W-1:0] ceil_blank;
    logic [7:0] max_cycles;
    logic [7:0] sleep_steps;
    logic [TIMER_W-1:0] sleep_base;
    logic [29:0] levels;
    logic [CAUSE_W-1:0] cause;
    logic [15:0] sample_cnt;
    logic startup;
    logic check_done;
    logic [TIMER_W-1:0] check_cnt;
    logic st_running;
    logic [TIMER_W-1:0] st_cnt;
    logic first_armed;
    logic [15:0] on_cnt;
    logic [TIMER_W-1:0] oc1_cnt;
    logic [TIMER_W-1:0] oc2_cnt;
    logic [TIMER_W-1:0] ceil_cnt;
    logic [7:0] nozc_cnt;
    logic [7:0] step_cnt;
    logic [TIMER_W-1:0] base_cnt;
    logic restart;
    logic [SETPOINT_W-1:0] setpoint;
    logic [31:0] prdata;
  } fps_state_s;
endpackage

// *** fps_stage_model.sv ***
`timescale 1ns/10ps
module fps_stage_model
  import fps_pkg::*;
(
  input wire logic ref_clk_i, // controller clock
  input wire logic rst_n_i, // supply lockout reset
  input wire logic gate_enable_i, // gates allowed to switch
  input wire fps_pkg::fps_sense_s cmd_i, // fault levels set by the bench
  output fps_pkg::fps_sense_s sense_o // comparators and phase flags
);
  import fps_pkg::*;
  logic [1:0] ph;
  // four-clock half-bridge cycle: two high-side clocks, two demag clocks
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph <= 2'h0;
    end else if (gate_enable_i) begin
      ph <= ph + 2'h1;
    end else begin
      ph <= 2'h0;
    end
  end
  always_comb begin
    sense_o = cmd_i;
    sense_o.hs_on = gate_enable_i && !ph[1];
    sense_o.hs_pulse_start = gate_enable_i && (ph == 2'h0);
    sense_o.demag = gate_enable_i && ph[1];
    sense_o.ls_on = gate_enable_i && ph[1];
    sense_o.hb_cycle_end = gate_enable_i && (ph == 2'h3);
    sense_o.zero_cross = gate_enable_i && (ph == 2'h3) && cmd_i.zero_cross;
    // no reflected voltage outside demag, so the under comparator trips there
    sense_o.aux_under_cmp = cmd_i.aux_under_cmp || !(gate_enable_i && ph[1]);
    sense_o.aux_over_cmp = cmd_i.aux_over_cmp && gate_enable_i && ph[1];
  end
endmodule

// *** fps_supervisor.sv ***
`timescale 1ns/10ps
module fps_supervisor
  import fps_pkg::*;
(
  input wire logic ref_clk_i, // controller clock
  input wire logic rst_n_i, // supply lockout reset
  input wire fps_pkg::fps_apb_req_s apb_i, // apb request
  output fps_pkg::fps_apb_rsp_s apb_o, // apb answer
  input wire fps_pkg::fps_sense_s sense_i, // comparators and phase flags
  input wire fps_pkg::fps_loop_s loop_i, // control loop set-points
  output logic gate_enable_o, // both gate drivers may switch
  output logic auto_restart_o, // in auto-restart sleep
  output logic latch_mode_o, // latched off
  output logic brown_in_mode_o, // bang-bang brown-in wait
  output logic restart_o, // pulse: sleep over, restart
  output logic burst_start_o, // burst on-frame may start
  output logic [fps_pkg::SETPOINT_W-1:0] current_setpoint_o // clamped set-point
);
  import fps_pkg::*;

  fps_state_s st;
  fps_state_s next_st;

  logic run;
  logic sample_tick;
  logic aux_window;
  logic uv_allowed;
  logic [SETPOINT_W-1:0] lev1;
  logic [SETPOINT_W-1:0] lev2;
  logic [SETPOINT_W-1:0] ceil;
  logic [CAUSE_W-1:0] fault;
  logic latch_fault;
  logic ar_fault;
  logic apb_setup;
  logic apb_write;
  logic mapped;
  logic base_wrap;

  assign lev1 = st.levels[LEV1_LSB +: SETPOINT_W];
  assign lev2 = st.levels[LEV2_LSB +: SETPOINT_W];
  assign ceil = st.levels[CEIL_LSB +: SETPOINT_W];
  assign run = (st.mode == ST_RUN);
  assign sample_tick = (st.sample_cnt + 16'h0001 >= st.sample_period);
  assign aux_window = sense_i.demag && sense_i.ls_on;
  // burst undervoltage only when software allows it
  assign uv_allowed = !sense_i.burst || st.ctrl[CTRL_BURST_UV_BIT];
  assign base_wrap = (st.base_cnt + 24'h000001 >= st.sleep_base);

  always_comb begin
    fault = '0;
    fault[CAUSE_INPUT_OV] = sample_tick && sense_i.input_overvoltage_cmp;
    fault[CAUSE_START_TO] = st.startup && st.st_running && (st.st_cnt >= st.start_to_limit)
      && !(loop_i.fb_setpoint < loop_i.startup_setpoint);
    fault[CAUSE_SHUNT] = st.first_armed && sense_i.hs_on
      && (st.on_cnt >= loop_i.first_pulse_on_limit);
    fault[CAUSE_OC1] = (st.oc1_cnt >= st.oc1_blank) && (st.setpoint > lev1);
    fault[CAUSE_OC2] = (st.oc2_cnt >= st.oc2_blank) && (st.setpoint > lev2);
    fault[CAUSE_CEIL] = (st.ceil_cnt >= st.ceil_blank) && (loop_i.fb_setpoint > ceil);
    fault[CAUSE_PEAK] = sense_i.peak_cmp;
    fault[CAUSE_OUT_UV] = aux_window && sense_i.aux_under_cmp && uv_allowed;
    fault[CAUSE_OUT_OV] = aux_window && sense_i.aux_over_cmp;
    fault[CAUSE_SHORT] = st.startup && (st.nozc_cnt > st.max_cycles);
    if (!run) begin
      fault = '0;
    end
  end

  // latch reasons win over restart reasons seen in the same cycle
  assign latch_fault = (fault[CAUSE_PEAK] && !st.ctrl[CTRL_PEAK_AR_BIT])
    || (fault[CAUSE_OUT_OV] && !st.ctrl[CTRL_OVP_AR_BIT]);
  assign ar_fault = |fault;

  assign apb_setup = apb_i.psel && !apb_i.penable;
  assign apb_write = apb_i.psel && apb_i.penable && apb_i.pwrite;
  assign mapped = (apb_i.paddr[1:0] == 2'h0) && (apb_i.paddr <= OFS_LEVELS);

  always_comb begin
    next_st = st;
    next_st.restart = 1'b0;
    next_st.cause = st.cause | fault;
    // register writes; status bits clear on write-one, new faults still win
    if (apb_write) begin
      case (apb_i.paddr)
        OFS_CTRL: next_st.ctrl = apb_i.pwdata[2:0];
        OFS_SAMPLE: next_st.sample_period = apb_i.pwdata[15:0];
        OFS_CHECK: next_st.check_limit = apb_i.pwdata[TIMER_W-1:0];
        OFS_START_TO: next_st.start_to_limit = apb_i.pwdata[TIMER_W-1:0];
        OFS_OC1_BLANK: next_st.oc1_blank = apb_i.pwdata[TIMER_W-1:0];
        OFS_OC2_BLANK: next_st.oc2_blank = apb_i.pwdata[TIMER_W-1:0];
        OFS_CEIL_BLANK: next_st.ceil_blank = apb_i.pwdata[TIMER_W-1:0];
        OFS_MAX_CYCLES: next_st.max_cycles = apb_i.pwdata[7:0];
        OFS_SLEEP_STEPS: next_st.sleep_steps = apb_i.pwdata[7:0];
        OFS_SLEEP_BASE: next_st.sleep_base = apb_i.pwdata[TIMER_W-1:0];
        OFS_STATUS: next_st.cause = (st.cause & ~apb_i.pwdata[CAUSE_W-1:0]) | fault;
        OFS_LEVELS: next_st.levels = apb_i.pwdata[29:0];
        default: next_st.ctrl = st.ctrl;
      endcase
    end
    // read data latched in the setup cycle, stable through access
    if (apb_setup) begin
      case (apb_i.paddr)
        OFS_CTRL: next_st.prdata = {29'h0, st.ctrl};
        OFS_SAMPLE: next_st.prdata = {16'h0, st.sample_period};
        OFS_CHECK: next_st.prdata = {8'h0, st.check_limit};
        OFS_START_TO: next_st.prdata = {8'h0, st.start_to_limit};
        OFS_OC1_BLANK: next_st.prdata = {8'h0, st.oc1_blank};
        OFS_OC2_BLANK: next_st.prdata = {8'h0, st.oc2_blank};
        OFS_CEIL_BLANK: next_st.prdata = {8'h0, st.ceil_blank};
        OFS_MAX_CYCLES: next_st.prdata = {24'h0, st.max_cycles};
        OFS_SLEEP_STEPS: next_st.prdata = {24'h0, st.sleep_steps};
        OFS_SLEEP_BASE: next_st.prdata = {8'h0, st.sleep_base};
        OFS_STATUS: next_st.prdata = {14'h0, st.mode, 6'h0, st.cause};
        OFS_LEVELS: next_st.prdata = {2'h0, st.levels};
        default: next_st.prdata = 32'h0000_0000;
      endcase
    end

    next_st.sample_cnt = sample_tick ? 16'h0000 : st.sample_cnt + 16'h0001;
    // clamp requested set-point at the ceiling
    next_st.setpoint = (loop_i.fb_setpoint > ceil) ? ceil : loop_i.fb_setpoint;
    next_st.oc1_cnt = (st.setpoint > lev1) ? st.oc1_cnt + 24'h000001 : '0;
    next_st.oc2_cnt = (st.setpoint > lev2) ? st.oc2_cnt + 24'h000001 : '0;
    next_st.ceil_cnt = (loop_i.fb_setpoint > ceil) ? st.ceil_cnt + 24'h000001 : '0;

    if (sense_i.startup_request) begin
      next_st.startup = 1'b1;
      next_st.st_running = 1'b0;
      next_st.st_cnt = '0;
      next_st.check_cnt = '0;
      next_st.check_done = 1'b0;
      next_st.first_armed = 1'b1;
      next_st.on_cnt = '0;
      next_st.nozc_cnt = '0;
    end else if (st.startup) begin
      if (sense_i.startup_done) begin
        next_st.startup = 1'b0;
        next_st.st_running = 1'b0;
        next_st.first_armed = 1'b0;
      end
      if (sense_i.hs_pulse_start || st.st_running) begin
        next_st.st_running = !sense_i.startup_done;
        next_st.st_cnt = st.st_running ? st.st_cnt + 24'h000001 : '0;
      end
      if (!st.check_done) begin
        next_st.check_cnt = st.check_cnt + 24'h000001;
        if (st.check_cnt >= st.check_limit) begin
          next_st.check_done = 1'b1;
        end
      end
      if (st.first_armed) begin
        // a pulse already running at the request is not the first pulse
        if (sense_i.hs_on && (st.on_cnt != 16'h0000 || sense_i.hs_pulse_start)) begin
          next_st.on_cnt = st.on_cnt + 16'h0001;
        end else if (st.on_cnt != 16'h0000) begin
          next_st.first_armed = 1'b0;
        end
      end
      if (sense_i.zero_cross) begin
        next_st.nozc_cnt = '0;
      end else if (sense_i.hb_cycle_end && st.nozc_cnt != 8'hFF) begin
        next_st.nozc_cnt = st.nozc_cnt + 8'h01;
      end
    end

    case (st.mode)
      ST_RUN: begin
        if (latch_fault) begin
          next_st.mode = ST_LATCH;
        end else if (ar_fault) begin
          next_st.mode = ST_SLEEP;
          next_st.step_cnt = '0;
          next_st.base_cnt = '0;
          next_st.ceil_cnt = '0;
          next_st.startup = 1'b0;
        end else if (st.startup && !st.check_done && st.check_cnt >= st.check_limit
            && (!sense_i.brown_in_ok || sense_i.input_overvoltage_cmp)) begin
          next_st.mode = ST_BROWNIN;
          next_st.startup = 1'b0;
        end
      end
      ST_SLEEP: begin
        next_st.ceil_cnt = '0;
        next_st.base_cnt = base_wrap ? '0 : st.base_cnt + 24'h000001;
        if (base_wrap) begin
          next_st.step_cnt = st.step_cnt + 8'h01;
          if (st.step_cnt + 8'h01 >= st.sleep_steps) begin
            next_st.mode = ST_RUN;
            next_st.restart = 1'b1;
          end
        end
      end
      ST_LATCH: begin
        next_st.mode = ST_LATCH;
      end
      ST_BROWNIN: begin
        if (sense_i.brown_in_ok && !sense_i.input_overvoltage_cmp) begin
          next_st.mode = ST_RUN;
        end
      end
      default: next_st.mode = ST_LATCH;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.mode <= ST_RUN;
      st.ctrl <= RST_CTRL;
      st.sample_period <= RST_SAMPLE;
      st.check_limit <= RST_CHECK;
      st.start_to_limit <= RST_START_TO;
      st.oc1_blank <= RST_OC1_BLANK;
      st.oc2_blank <= RST_OC2_BLANK;
      st.ceil_blank <= RST_CEIL_BLANK;
      st.max_cycles <= RST_MAX_CYCLES;
      st.sleep_steps <= RST_SLEEP_STEPS;
      st.sleep_base <= RST_SLEEP_BASE;
      st.levels <= RST_LEVELS;
    end else begin
      st <= next_st;
    end
  end

  assign apb_o.pready = 1'b1;
  assign apb_o.pslverr = apb_i.psel && apb_i.penable && !mapped;
  assign apb_o.prdata = st.prdata;
  assign gate_enable_o = run;
  assign auto_restart_o = (st.mode == ST_SLEEP);
  assign latch_mode_o = (st.mode == ST_LATCH);
  assign brown_in_mode_o = (st.mode == ST_BROWNIN);
  assign restart_o = st.restart;
  assign current_setpoint_o = st.setpoint;
  // frame start held off while the input is over range
  assign burst_start_o = run && sense_i.wake && !sense_i.input_overvoltage_cmp;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_in_run;
    st.mode == ST_RUN;
  endsequence

  property p_input_ov;
    s_in_run ##0 (sample_tick && sense_i.input_overvoltage_cmp && !latch_fault) |=> auto_restart_o;
  endproperty
  a_input_ov: assert property (p_input_ov) else $error("input overvoltage not restarted");

  property p_burst_start;
    burst_start_o |-> (sense_i.wake && !sense_i.input_overvoltage_cmp);
  endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst frame during overvoltage");

  property p_first_pulse;
    s_in_run ##0 (st.first_armed && sense_i.hs_on && st.on_cnt >= loop_i.first_pulse_on_limit)
      |=> !gate_enable_o;
  endproperty
  a_first_pulse: assert property (p_first_pulse) else $error("first pulse limit ignored");

  property p_peak_latch;
    s_in_run ##0 (sense_i.peak_cmp && !st.ctrl[CTRL_PEAK_AR_BIT]) |=> latch_mode_o;
  endproperty
  a_peak_latch: assert property (p_peak_latch) else $error("peak overcurrent not latched");

  property p_uv_suppressed;
    s_in_run ##0 (sense_i.burst && !st.ctrl[CTRL_BURST_UV_BIT]) |-> !fault[CAUSE_OUT_UV];
  endproperty
  a_uv_suppressed: assert property (p_uv_suppressed) else $error("burst undervoltage seen");

  property p_ov_select;
    s_in_run ##0 (aux_window && sense_i.aux_over_cmp)
      |=> (st.ctrl[CTRL_OVP_AR_BIT] ? auto_restart_o : latch_mode_o);
  endproperty
  a_ov_select: assert property (p_ov_select) else $error("output overvoltage wrong mode");

  property p_gates_off;
    (auto_restart_o || latch_mode_o) |-> !gate_enable_o;
  endproperty
  a_gates_off: assert property (p_gates_off) else $error("gates enabled in protection");

  property p_latch_holds;
    latch_mode_o |=> latch_mode_o [*8];
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("latch mode left");

  property p_ceil_clear;
    auto_restart_o |-> st.ceil_cnt == '0 ##1 1'b1;
  endproperty
  a_ceil_clear: assert property (p_ceil_clear) else $error("ceiling timer not cleared");
endmodule
